// ==== hw/spe_pkg.sv ====
// Shared constants, types and register map of the serial programming entry host.
package spe_pkg;

  // Register map, byte offsets on the AHB-Lite port.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_OPCODE = 8'h04;
  localparam logic [7:0] OFF_INSTR = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;

  // Control register command bits, each a write-one strobe.
  localparam int CTRL_ENTER_BIT = 0;
  localparam int CTRL_EXIT_BIT = 1;
  localparam int CTRL_RUN_BIT = 2;
  localparam int CTRL_RAW_BIT = 3;

  // Status register field positions.
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_MODE_BIT = 1;
  localparam int STAT_PIN_BIT = 2;
  localparam int STAT_ERR_BIT = 3;
  localparam int STAT_ERASED_BIT = 4;
  localparam int STAT_STATE_LSB = 8;
  localparam int STAT_STEP_LSB = 12;

  // Reset values of the software registers.
  localparam logic [15:0] RST_OPCODE = 16'h407F;
  localparam logic [23:0] RST_INSTR = 24'h000000;

  // Entry key, sent most significant bit first.
  localparam logic [31:0] ACCESS_KEY = 32'h4D434851;

  // Flash operation codes loaded into flash_op_control_reg.
  localparam logic [15:0] OP_ERASE_ALL = 16'h407F;
  localparam logic [15:0] OP_ERASE_BOOT_GEN = 16'h406E;
  localparam logic [15:0] OP_ERASE_GEN_CFG = 16'h404E;
  localparam logic [15:0] OP_ERASE_GEN = 16'h4042;
  localparam logic [15:0] OP_ERASE_EXEC = 16'h4072;
  localparam logic [15:0] OP_ERASE_ROW = 16'h4071;
  localparam logic [15:0] OP_WRITE_CFG = 16'h4008;
  localparam logic [15:0] OP_WRITE_ROW = 16'h4001;

  // Instruction words of the erase or write sequence.
  localparam logic [23:0] INS_GOTO_100 = 24'h040100;
  localparam logic [23:0] INS_NOP = 24'h000000;
  localparam logic [3:0] INS_MOVLIT_HI = 4'h2;
  localparam logic [3:0] INS_MOVLIT_W10 = 4'hA;
  localparam logic [23:0] INS_W10_TO_CTL = 24'h883B0A;
  localparam logic [23:0] INS_55_TO_W8 = 24'h200558;
  localparam logic [23:0] INS_W8_TO_KEY = 24'h883B38;
  localparam logic [23:0] INS_AA_TO_W9 = 24'h200AA9;
  localparam logic [23:0] INS_W9_TO_KEY = 24'h883B39;
  localparam logic [23:0] INS_SET_START = 24'hA8E761;
  localparam logic [23:0] INS_CLR_START = 24'hA9E761;

  // Sequence step indices around the externally timed hold.
  localparam logic [4:0] STEP_LAST_PRE = 5'h0E;
  localparam logic [4:0] STEP_CLR = 5'h0F;
  localparam logic [4:0] STEP_LAST = 5'h13;

  // Serial framing: control code, instruction length, extra clocks after reset.
  localparam logic [3:0] CODE_EXEC = 4'h0;
  localparam logic [5:0] SIX_BITS = 6'h1C;
  localparam logic [5:0] FIRST_EXTRA = 6'h05;
  localparam logic [5:0] KEY_BITS = 6'h20;

  // Timing in its own units and the derived cycle counts at 25 MHz.
  localparam int CLK_PERIOD_NS = 40;
  localparam int P16_NS = 1000;
  localparam int P17_NS = 100;
  localparam int P7_NS = 25000;
  localparam int PGC_HALF_NS = 100;
  localparam int WR_HOLD_MS = 2;
  localparam int P16_CYC = (P16_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC = (P17_NS + P7_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PGC_HALF_CYC = (PGC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_HOLD_CYC = (WR_HOLD_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Sequencer states.
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_PULSE = 4'h1,
    ST_P16 = 4'h2,
    ST_KEY = 4'h3,
    ST_SETTLE = 4'h4,
    ST_READY = 4'h5,
    ST_ISSUE = 4'h6,
    ST_SEQ = 4'h7,
    ST_HOLD = 4'h8,
    ST_RAW = 4'h9
  } spe_state_type;

  // One request to the serial shifter, bits sent from word[0] upward.
  typedef struct packed {
    logic start;
    logic [5:0] nbits;
    logic [32:0] word;
  } spe_shift_req_type;

endpackage

// ==== hw/spe_sync.sv ====
// Three-stage input synchroniser that passes a level once two stages agree.
`timescale 1ns/1ps
module spe_sync
  import spe_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic d_i,
  output logic q_o
);

  logic ff1;
  logic ff2;
  logic ff3;

  // The first stage feeds only the second, so a metastable level never fans out.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ff1 <= 1'b0;
      ff2 <= 1'b0;
      ff3 <= 1'b0;
    end
    else if (ce_i)
    begin
      ff1 <= d_i;
      ff2 <= ff1;
      ff3 <= ff2;
    end
  end

  // A change is accepted only when the last two stages hold the same level.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      q_o <= 1'b0;
    else if (ce_i && (ff2 == ff3))
      q_o <= ff3;
  end

endmodule // spe_sync

// ==== hw/spe_shifter.sv ====
// Serial shifter that makes the programming clock and sends a word LSB first.
`timescale 1ns/1ps
module spe_shifter
  import spe_pkg::*;
#(
  parameter int WORD_W = 33,
  parameter int HALF_CYC = PGC_HALF_CYC
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire spe_shift_req_type req_i,
  output logic pgc_o,
  output logic pgd_o,
  output logic busy_o,
  output logic done_o
);

  logic [WORD_W-1:0] sh;
  logic [5:0] left;
  logic [3:0] div;

  // Data changes together with each rising edge and holds across the falling
  // edge, where the device latches it; a request is taken only while idle.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      sh <= '0;
      left <= 6'h00;
      div <= 4'h0;
      pgc_o <= 1'b0;
      pgd_o <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end
    else if (ce_i)
    begin
      done_o <= 1'b0;
      if (!busy_o)
      begin
        if (req_i.start && (req_i.nbits != 6'h00))
        begin
          busy_o <= 1'b1;
          pgc_o <= 1'b1;
          pgd_o <= req_i.word[0];
          sh <= WORD_W'(req_i.word >> 1);
          left <= req_i.nbits - 6'h01;
          div <= 4'h0;
        end
      end
      else if (div == 4'(HALF_CYC - 1))
      begin
        div <= 4'h0;
        if (pgc_o)
          pgc_o <= 1'b0;
        else if (left == 6'h00)
        begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end
        else
        begin
          pgc_o <= 1'b1;
          pgd_o <= sh[0];
          sh <= sh >> 1;
          left <= left - 6'h01;
        end
      end
      else
        div <= div + 4'h1;
    end
  end

endmodule // spe_shifter

// ==== hw/spe_prog_host.sv ====
// Programmer that enters serial programming mode and runs timed flash cycles.
//
// The implementer's own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module spe_prog_host
  import spe_pkg::*;
#(
  parameter int WR_HOLD_CYCLES = WR_HOLD_CYC
)
(
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  output logic MASTER_CLEAR_PIN_O,
  output logic PROG_CLOCK_PIN_O,
  output logic PROG_DATA_PIN_O,
  output logic PROG_DATA_PIN_OE_N_O,
  input wire logic PROG_DATA_PIN_I
);

  spe_state_type state;
  spe_shift_req_type shift_req;
  logic [31:0] key_lsb;
  logic [15:0] opcode;
  logic [23:0] instr;
  logic [19:0] cnt;
  logic [4:0] step;
  logic in_mode;
  logic first_six;
  logic erased;
  logic err;
  logic pin_level;
  logic shift_busy;
  logic shift_done;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic cmd_enter;
  logic cmd_exit;
  logic cmd_run;
  logic cmd_raw;
  logic op_known;
  logic op_is_erase;
  logic op_needs_erase;
  logic busy;

  // Bit-reverse the key so the shifter, which always sends bit 0 first, puts
  // the key's top bit on the pin first.
  genvar g;
  generate
    for (g = 0; g < 32; g++)
    begin : g_key
      assign key_lsb[g] = ACCESS_KEY[31 - g];
    end
  endgenerate

  // Decode of the loaded operation code.
  always_comb
  begin
    op_known = 1'b1;
    op_is_erase = 1'b1;
    op_needs_erase = 1'b0;
    case (opcode)
      OP_ERASE_ALL, OP_ERASE_BOOT_GEN, OP_ERASE_GEN_CFG, OP_ERASE_GEN: op_is_erase = 1'b1;
      OP_ERASE_EXEC, OP_ERASE_ROW: op_is_erase = 1'b1;
      OP_WRITE_CFG: op_is_erase = 1'b0;
      OP_WRITE_ROW:
      begin
        op_is_erase = 1'b0;
        op_needs_erase = 1'b1;
      end
      default:
      begin
        op_known = 1'b0;
        op_is_erase = 1'b0;
      end
    endcase
  end

  // Busy covers the sequencer and any frame still on the pins.
  assign busy = ((state != ST_IDLE) && (state != ST_READY)) || shift_busy;

  // Instruction sent at each step of an erase or write cycle.
  function automatic logic [23:0] step_instr(input logic [4:0] s, input logic [15:0] op);
    logic [23:0] w;
    w = INS_NOP;
    case (s)
      5'h00, 5'h01: w = INS_GOTO_100;
      5'h03: w = {INS_MOVLIT_HI, op, INS_MOVLIT_W10};
      5'h04: w = INS_W10_TO_CTL;
      5'h05: w = INS_55_TO_W8;
      5'h06: w = INS_W8_TO_KEY;
      5'h07: w = INS_AA_TO_W9;
      5'h08: w = INS_W9_TO_KEY;
      5'h09: w = INS_SET_START;
      STEP_CLR: w = INS_CLR_START;
      default: w = INS_NOP;
    endcase
    return w;
  endfunction

  // Frames one instruction behind control code 0000, low bit first; the first
  // frame after entry carries the extra clocks the device needs after reset.
  function automatic spe_shift_req_type six_req(input logic [23:0] ins, input logic first);
    spe_shift_req_type r;
    r.start = 1'b1;
    if (first)
    begin
      r.nbits = SIX_BITS + FIRST_EXTRA;
      r.word = {ins, CODE_EXEC, 5'h00};
    end
    else
    begin
      r.nbits = SIX_BITS;
      r.word = {5'h00, ins, CODE_EXEC};
    end
    return r;
  endfunction

  // Address phase: latch the write target and prepare read data, so a read
  // answers in its data phase with no wait state.
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RST_N_I)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      HRDATA_O <= 32'h00000000;
    end
    else if (CE_I && HREADY_I)
    begin
      wr_pend <= HSEL_I && HTRANS_I[1] && HWRITE_I;
      wr_addr <= HADDR_I[7:0];
      if (HSEL_I && HTRANS_I[1] && !HWRITE_I)
      begin
        case (HADDR_I[7:0])
          OFF_OPCODE: HRDATA_O <= {16'h0000, opcode};
          OFF_INSTR: HRDATA_O <= {8'h00, instr};
          OFF_STATUS:
          begin
            HRDATA_O <= 32'h00000000;
            HRDATA_O[STAT_BUSY_BIT] <= busy;
            HRDATA_O[STAT_MODE_BIT] <= in_mode;
            HRDATA_O[STAT_PIN_BIT] <= pin_level;
            HRDATA_O[STAT_ERR_BIT] <= err;
            HRDATA_O[STAT_ERASED_BIT] <= erased;
            HRDATA_O[STAT_STATE_LSB +: 4] <= state;
            HRDATA_O[STAT_STEP_LSB +: 5] <= step;
          end
          default: HRDATA_O <= 32'h00000000;
        endcase
      end
    end
  end

  // The slave never stalls and never reports an error.
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RST_N_I)
    begin
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
    end
    else if (CE_I)
    begin
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
    end
  end

  // Data phase writes: data registers and one-cycle command strobes.
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RST_N_I)
    begin
      opcode <= RST_OPCODE;
      instr <= RST_INSTR;
      cmd_enter <= 1'b0;
      cmd_exit <= 1'b0;
      cmd_run <= 1'b0;
      cmd_raw <= 1'b0;
    end
    else if (CE_I)
    begin
      cmd_enter <= 1'b0;
      cmd_exit <= 1'b0;
      cmd_run <= 1'b0;
      cmd_raw <= 1'b0;
      if (wr_pend)
      begin
        case (wr_addr)
          OFF_CTRL:
          begin
            cmd_enter <= HWDATA_I[CTRL_ENTER_BIT];
            cmd_exit <= HWDATA_I[CTRL_EXIT_BIT];
            cmd_run <= HWDATA_I[CTRL_RUN_BIT];
            cmd_raw <= HWDATA_I[CTRL_RAW_BIT];
          end
          OFF_OPCODE: opcode <= HWDATA_I[15:0];
          OFF_INSTR: instr <= HWDATA_I[23:0];
          default: opcode <= opcode;
        endcase
      end
    end
  end

  // Sequencer for mode entry, exit and the timed flash cycles.
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RST_N_I)
    begin
      state <= ST_IDLE;
      shift_req <= '0;
      cnt <= 20'h00000;
      step <= 5'h00;
      in_mode <= 1'b0;
      first_six <= 1'b0;
      erased <= 1'b0;
      err <= 1'b0;
      MASTER_CLEAR_PIN_O <= 1'b0;
    end
    else if (CE_I)
    begin
      shift_req.start <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (cmd_enter)
          begin
            MASTER_CLEAR_PIN_O <= 1'b1;
            first_six <= 1'b1;
            erased <= 1'b0;
            err <= 1'b0;
            state <= ST_PULSE;
          end
          else if (cmd_exit || cmd_run || cmd_raw)
            err <= 1'b1;
        end
        ST_PULSE:
        begin
          MASTER_CLEAR_PIN_O <= 1'b0;
          cnt <= 20'(P16_CYC);
          state <= ST_P16;
        end
        ST_P16:
        begin
          if (cnt <= 20'h00001)
          begin
            shift_req <= '{start: 1'b1, nbits: KEY_BITS, word: {1'b0, key_lsb}};
            state <= ST_KEY;
          end
          else
            cnt <= cnt - 20'h00001;
        end
        ST_KEY:
        begin
          if (shift_done)
          begin
            MASTER_CLEAR_PIN_O <= 1'b1;
            cnt <= 20'(SETTLE_CYC);
            state <= ST_SETTLE;
          end
        end
        ST_SETTLE:
        begin
          if (cnt <= 20'h00001)
          begin
            in_mode <= 1'b1;
            state <= ST_READY;
          end
          else
            cnt <= cnt - 20'h00001;
        end
        ST_READY:
        begin
          if (cmd_exit)
          begin
            MASTER_CLEAR_PIN_O <= 1'b0;
            in_mode <= 1'b0;
            err <= 1'b0;
            state <= ST_IDLE;
          end
          else if (cmd_run)
          begin
            if (!op_known || (op_needs_erase && !erased))
              err <= 1'b1;
            else
            begin
              err <= 1'b0;
              step <= 5'h00;
              state <= ST_ISSUE;
            end
          end
          else if (cmd_raw)
          begin
            err <= 1'b0;
            shift_req <= six_req(instr, first_six);
            state <= ST_RAW;
          end
          else if (cmd_enter)
            err <= 1'b1;
        end
        ST_ISSUE:
        begin
          shift_req <= six_req(step_instr(step, opcode), first_six);
          state <= ST_SEQ;
        end
        ST_SEQ:
        begin
          if (shift_done)
          begin
            first_six <= 1'b0;
            if (step == STEP_LAST_PRE)
            begin
              cnt <= 20'(WR_HOLD_CYCLES);
              state <= ST_HOLD;
            end
            else if (step == STEP_LAST)
            begin
              erased <= erased | op_is_erase;
              state <= ST_READY;
            end
            else
            begin
              step <= step + 5'h01;
              state <= ST_ISSUE;
            end
          end
        end
        ST_HOLD:
        begin
          if (cnt <= 20'h00001)
          begin
            step <= STEP_CLR;
            state <= ST_ISSUE;
          end
          else
            cnt <= cnt - 20'h00001;
        end
        ST_RAW:
        begin
          if (shift_done)
          begin
            first_six <= 1'b0;
            state <= ST_READY;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // The data pin is driven from the start of entry until exit, and released
  // while idle so a board can use it for something else.
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RST_N_I)
      PROG_DATA_PIN_OE_N_O <= 1'b1;
    else if (CE_I)
      PROG_DATA_PIN_OE_N_O <= (state == ST_IDLE) && !cmd_enter;
  end

  // Clock and data come from the shifter's own flip-flops.
  spe_shifter #(
    .WORD_W(33),
    .HALF_CYC(PGC_HALF_CYC)
  ) u_shifter (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RST_N_I),
    .ce_i(CE_I),
    .req_i(shift_req),
    .pgc_o(PROG_CLOCK_PIN_O),
    .pgd_o(PROG_DATA_PIN_O),
    .busy_o(shift_busy),
    .done_o(shift_done)
  );

  // The data pin level comes from outside the clock domain.
  spe_sync u_pin_sync (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RST_N_I),
    .ce_i(CE_I),
    .d_i(PROG_DATA_PIN_I),
    .q_o(pin_level)
  );

endmodule // spe_prog_host

// ==== bench/spe_prog_host_asserts.sv ====
// Pin and bus checks for the programming host.
`timescale 1ns/1ps
module spe_prog_host_asserts
  import spe_pkg::*;
#(
  parameter int WR_HOLD_CYCLES = WR_HOLD_CYC
)
(
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic HREADYOUT_O,
  input wire logic HRESP_O,
  input wire logic MASTER_CLEAR_PIN_O,
  input wire logic PROG_CLOCK_PIN_O,
  input wire logic PROG_DATA_PIN_O,
  input wire logic PROG_DATA_PIN_OE_N_O
);
  logic mc_q;
  logic key_sent;
  logic [15:0] up_n;
  logic [15:0] dn_n;
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  // Cycles since master clear rose or fell; they saturate so idles never wrap.
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RST_N_I)
    begin
      mc_q <= 1'b0;
      key_sent <= 1'b0;
      up_n <= 16'h0000;
      dn_n <= 16'h0000;
    end
    else
    begin
      mc_q <= MASTER_CLEAR_PIN_O;
      up_n <= (MASTER_CLEAR_PIN_O && !mc_q) ? 16'h0001 : up_n + {15'h0, up_n != 16'hFFFF};
      dn_n <= (!MASTER_CLEAR_PIN_O && mc_q) ? 16'h0001 : dn_n + {15'h0, dn_n != 16'hFFFF};
      key_sent <= (MASTER_CLEAR_PIN_O && !mc_q) ? 1'b0 :
        (key_sent || (PROG_CLOCK_PIN_O && !MASTER_CLEAR_PIN_O));
    end
  end
  a_ready_no_wait: assert property (HREADYOUT_O)
    else $error("bus wait state seen");
  a_resp_okay: assert property (!HRESP_O)
    else $error("error response seen");
  a_pulse_one_cycle: assert property (
    $rose(MASTER_CLEAR_PIN_O) && !key_sent |=> !MASTER_CLEAR_PIN_O)
    else $error("opening pulse too long");
  a_mode_clear_held: assert property (
    $rose(MASTER_CLEAR_PIN_O) && key_sent |=> MASTER_CLEAR_PIN_O[*8])
    else $error("master clear not held");
  a_key_gap_wait: assert property (
    $rose(PROG_CLOCK_PIN_O) && !MASTER_CLEAR_PIN_O |-> dn_n >= P16_CYC)
    else $error("key started too early");
  a_settle_gap_wait: assert property (
    $rose(PROG_CLOCK_PIN_O) && MASTER_CLEAR_PIN_O |-> up_n >= SETTLE_CYC)
    else $error("data clocked before settle");
  a_bit_high_three: assert property (
    $rose(PROG_CLOCK_PIN_O) |-> PROG_CLOCK_PIN_O[*3] ##1 !PROG_CLOCK_PIN_O)
    else $error("clock high phase wrong");
  a_data_stable_fall: assert property (
    $fell(PROG_CLOCK_PIN_O) && !PROG_DATA_PIN_OE_N_O |-> $stable(PROG_DATA_PIN_O))
    else $error("data moved at falling clock");
  a_drive_while_clk: assert property (
    PROG_CLOCK_PIN_O |-> !PROG_DATA_PIN_OE_N_O)
    else $error("data released while clocking");
endmodule // spe_prog_host_asserts
bind spe_prog_host spe_prog_host_asserts #(.WR_HOLD_CYCLES(WR_HOLD_CYCLES)) i_chk (
  .SYS_CLK_I(SYS_CLK_I),
  .RST_N_I(RST_N_I),
  .HREADYOUT_O(HREADYOUT_O),
  .HRESP_O(HRESP_O),
  .MASTER_CLEAR_PIN_O(MASTER_CLEAR_PIN_O),
  .PROG_CLOCK_PIN_O(PROG_CLOCK_PIN_O),
  .PROG_DATA_PIN_O(PROG_DATA_PIN_O),
  .PROG_DATA_PIN_OE_N_O(PROG_DATA_PIN_OE_N_O)
);

// ==== bench/spe_dev_model.sv ====
// Behavioural target device behind the programming pins.
`timescale 1ns/1ps
module spe_dev_model
  import spe_pkg::*;
(
  input wire logic clk_i,
  input wire logic master_clear_pin_i,
  input wire logic pgc_i,
  input wire logic pgd_i,
  input wire logic oe_n_i,
  output logic pin_o,
  output logic in_mode_o = 1'b0,
  output logic [31:0] key_o = 32'h0,
  output logic [23:0] instr_o = 24'h0,
  output int frames_o = 0,
  output int cycles_o = 0,
  output logic [15:0] op_o = 16'h0
);
  logic [15:0] w [16];
  logic [15:0] sel_op;
  logic [27:0] sh;
  logic [1:0] unlock = 2'h0;
  logic wr = 1'b0;
  int nbit = -5;
  int hold = 0;
  // The device keeps its own pins floating, so only the host's level shows here.
  // No pull on this line, so a released pin shows the inverse of the last level.
  assign pin_o = oe_n_i ? ~pgd_i : pgd_i;
  // Any pulse length is taken; the mode needs the exact key and lasts while clear is high.
  always @(master_clear_pin_i)
  begin
    in_mode_o = master_clear_pin_i && (key_o == ACCESS_KEY);
    nbit = -5;
  end
  // Bits latch on the falling clock; the first frame carries five extra clocks.
  always @(negedge pgc_i)
  begin
    if (!master_clear_pin_i)
      key_o = {key_o[30:0], pgd_i};
    else if (in_mode_o)
    begin
      nbit++;
      if (nbit > 0)
        sh = {pgd_i, sh[27:1]};
      if (nbit == 28)
      begin
        nbit = 0;
        frames_o++;
        instr_o = sh[27:4];
        if (sh[3:0] == CODE_EXEC)
          execute();
      end
    end
  end
  // Start-to-clear spacing in system clocks.
  always @(posedge clk_i)
    hold <= wr ? hold + 1 : 0;
  task automatic execute();
    if (instr_o[23:20] == INS_MOVLIT_HI)
      w[instr_o[3:0]] = instr_o[19:4];
    else if (instr_o == INS_W10_TO_CTL)
      sel_op = w[10];
    else if (instr_o == INS_W8_TO_KEY)
      unlock = (w[8] == 16'h0055) ? 2'h1 : 2'h0;
    else if (instr_o == INS_W9_TO_KEY)
      unlock = (unlock == 2'h1 && w[9] == 16'h00AA) ? 2'h2 : 2'h0;
    else if (instr_o == INS_SET_START)
      wr = (unlock == 2'h2);
    else if (instr_o == INS_CLR_START && wr)
    begin
      wr = 1'b0;
      cycles_o = hold;
      op_o = sel_op;
    end
    if (instr_o[23:20] != INS_MOVLIT_HI && instr_o != INS_W8_TO_KEY)
      unlock = (instr_o == INS_W9_TO_KEY) ? unlock : 2'h0;
  endtask
endmodule // spe_dev_model

// ==== bench/tb.sv ====
// Self-checking bench for the programming host.
`timescale 1ns/1ps
module tb import spe_pkg::*;;
  localparam int HOLD = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hrdata;
  logic hready, hresp, master_clear_pin, prog_clock_pin, prog_data_pin, oe_n, pin, in_mode;
  logic [31:0] key;
  logic [23:0] instr;
  logic [15:0] dop;
  int frames, cycles;
  int num_errors = 0;
  int cmp_count = 0;
  always #20 clk = ~clk;
  spe_prog_host #(.WR_HOLD_CYCLES(HOLD)) i_spe_prog_host (.SYS_CLK_I(clk), .RST_N_I(rst_n),
    .CE_I(1'b1), .HSEL_I(1'b1), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
    .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
    .HREADYOUT_O(hready), .HRESP_O(hresp), .MASTER_CLEAR_PIN_O(master_clear_pin),
    .PROG_CLOCK_PIN_O(prog_clock_pin), .PROG_DATA_PIN_O(prog_data_pin), .PROG_DATA_PIN_OE_N_O(oe_n),
    .PROG_DATA_PIN_I(pin));
  spe_dev_model i_spe_dev_model (.clk_i(clk), .master_clear_pin_i(master_clear_pin), .pgc_i(prog_clock_pin), .pgd_i(prog_data_pin),
    .oe_n_i(oe_n), .pin_o(pin), .in_mode_o(in_mode), .key_o(key), .instr_o(instr),
    .frames_o(frames), .cycles_o(cycles), .op_o(dop));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic chk_bit(input logic [31:0] q, input int b, input logic v, input string m);
    chk({31'h0, q[b]}, {31'h0, v}, m);
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask
  task automatic cmd(input int b);
    wr(OFF_CTRL, 32'h1 << b);
    repeat (2) @(posedge clk);
  endtask
  task automatic stat(output logic [31:0] q);
    ahb(1'b0, OFF_STATUS, 32'h0, q);
  endtask
  task automatic wait_bit(input int b, input logic v);
    logic [31:0] s;
    stat(s);
    for (int i = 0; i < 3000 && s[b] !== v; i++)
      stat(s);
    chk_bit(s, b, v, "status wait");
  endtask
  task automatic t_reset();
    logic [31:0] q;
    stat(q);
    chk(q, 32'h1 << STAT_PIN_BIT, "idle status");
    ahb(1'b0, OFF_OPCODE, 32'h0, q);
    chk(q, {16'h0, RST_OPCODE}, "opcode reset");
    wr(8'h10, 32'hFFFFFFFF);
    ahb(1'b0, 8'h10, 32'h0, q);
    chk(q, 32'h0, "unmapped read");
    ahb(1'b0, OFF_CTRL, 32'h0, q);
    chk(q, 32'h0, "control read");
    $display("test reset done");
  endtask
  task automatic t_refuse(input logic [15:0] op);
    logic [31:0] q;
    int f0;
    f0 = frames;
    wr(OFF_OPCODE, {16'h0, op});
    cmd(CTRL_RUN_BIT);
    stat(q);
    chk_bit(q, STAT_ERR_BIT, 1'b1, "refusal flag");
    chk(frames - f0, 32'h0, "nothing shifted");
    $display("test refuse done");
  endtask
  task automatic t_enter();
    cmd(CTRL_ENTER_BIT);
    wait_bit(STAT_MODE_BIT, 1'b1);
    chk({31'h0, in_mode}, 32'h1, "device mode");
    chk(key, ACCESS_KEY, "key order");
    chk({31'h0, master_clear_pin}, 32'h1, "clear held");
    $display("test enter done");
  endtask
  task automatic t_ops();
    logic [15:0] ops [8] = '{OP_ERASE_ALL, OP_ERASE_BOOT_GEN, OP_ERASE_GEN_CFG,
      OP_ERASE_GEN, OP_ERASE_EXEC, OP_ERASE_ROW, OP_WRITE_CFG, OP_WRITE_ROW};
    logic [31:0] q;
    int f0;
    foreach (ops[i])
    begin
      f0 = frames;
      wr(OFF_OPCODE, {16'h0, ops[i]});
      cmd(CTRL_RUN_BIT);
      wait_bit(STAT_BUSY_BIT, 1'b0);
      chk({16'h0, dop}, {16'h0, ops[i]}, "cycle done");
      chk(frames - f0, 32'd20, "frame count");
      // Five no-ops and the clear frame alone take 6 * 28 bit periods; the rest is the hold.
      chk({31'h0, cycles >= HOLD + 6 * 28 * 2 * PGC_HALF_CYC}, 32'h1, "hold span");
      stat(q);
      chk_bit(q, STAT_ERR_BIT, 1'b0, "flag cleared");
      chk_bit(q, STAT_ERASED_BIT, 1'b1, "erased flag");
    end
    $display("test ops done");
  endtask
  task automatic t_raw();
    int f0;
    f0 = frames;
    wr(OFF_INSTR, 32'h00A5C3E1);
    cmd(CTRL_RAW_BIT);
    wait_bit(STAT_BUSY_BIT, 1'b0);
    chk({8'h0, instr}, 32'h00A5C3E1, "raw word");
    chk(frames - f0, 32'h1, "raw frame");
    $display("test raw done");
  endtask
  task automatic t_exit();
    cmd(CTRL_EXIT_BIT);
    wait_bit(STAT_MODE_BIT, 1'b0);
    chk({30'h0, master_clear_pin, in_mode}, 32'h0, "mode left");
    $display("test exit done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence after a twelve cycle reset.
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    // The pin level needs four edges to pass the synchroniser before status shows it.
    repeat (4) @(posedge clk);
    t_reset();
    t_refuse(OP_ERASE_ALL);
    t_enter();
    t_refuse(16'h1234);
    t_refuse(OP_WRITE_ROW);
    t_ops();
    t_raw();
    t_exit();
    report_and_stop();
  end
  // Watchdog sized well above the roughly 29000 cycles the tests need.
  initial
  begin
    repeat (90000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end
endmodule // tb
